/* File: bst_sync.sv */
// holds the tap package (states, instruction codes, widths) and the pin synchroniser
// assumes every tap pin is asynchronous to clk and changes far slower than clk
package bst_pkg;
	// ----------------------------------------------------------------
	// widths and instruction codes
	// ----------------------------------------------------------------
	localparam int IR_LEN = 4;
	localparam int ID_LEN = 32;
	localparam logic [IR_LEN-1:0] IR_EXTEST = 4'h0;
	localparam logic [IR_LEN-1:0] IR_IDCODE = 4'h1;
	localparam logic [IR_LEN-1:0] IR_SAMPLE = 4'h2;
	localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hF;
	localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
	localparam int SYNC_W = 5;

	// ----------------------------------------------------------------
	// controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_TLR = 4'hF,
		ST_RTI = 4'hC,
		ST_SEL_DR = 4'h7,
		ST_CAP_DR = 4'h6,
		ST_SH_DR = 4'h2,
		ST_EX1_DR = 4'h1,
		ST_PA_DR = 4'h3,
		ST_EX2_DR = 4'h0,
		ST_UPD_DR = 4'h5,
		ST_SEL_IR = 4'h4,
		ST_CAP_IR = 4'hE,
		ST_SH_IR = 4'hA,
		ST_EX1_IR = 4'h9,
		ST_PA_IR = 4'hB,
		ST_EX2_IR = 4'h8,
		ST_UPD_IR = 4'hD
	} bst_state_e;
endpackage : bst_pkg

`timescale 1ns/1ps

module bst_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} bst_sync_s;

	bst_sync_s s_r;
	bst_sync_s s_nxt;

	// first stage feeds only the second stage
	always_comb
	begin
		s_nxt.meta = d;
		s_nxt.stable = s_r.meta;
	end

	// two flip-flops per pin
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign q = s_r.stable;
endmodule : bst_sync

/* File: bst_tap.sv */
// test access port for boundary scan: controller, instruction, bypass, id and boundary registers
// assumes the tap pins come from an outside tester; tap_clock is sampled by clk, far slower than clk
// Notes on behaviour
// - a low tap_reset_n resets the controller at once, without tap_clock
// - leaving reset puts the identification instruction in place, port usable
// - framer_compat_select high holds the controller in reset
// - tap_mode_select sampled at each tap_clock rise steps the controller
// - tap_serial_in is captured into the shifting register at tap_clock rises
// - tap_serial_out changes only at tap_clock falls and when a reset clears it
// - compat select low gives native mode, high gives legacy mode
`timescale 1ns/1ps

module bst_tap
	import bst_pkg::*;
#(
	parameter int BSR_LEN = 8,
	parameter logic [ID_LEN-1:0] IDCODE_VAL = 32'h0000_0001 // arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tap_clock,
	input wire logic tap_reset_n,
	input wire logic tap_mode_select,
	input wire logic tap_serial_in,
	input wire logic framer_compat_select,
	input wire logic [BSR_LEN-1:0] bsr_capture,
	output logic tap_serial_out,
	output logic tap_serial_out_oe_n,
	output logic [BSR_LEN-1:0] bsr_update,
	output logic extest_active,
	output logic legacy_mode
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (BSR_LEN < 2)
	begin : g_bad_len
		$error("boundary register needs at least two cells");
	end
	if (IDCODE_VAL[0] != 1'b1)
	begin : g_bad_id
		$error("id value must end in a one");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] pins_s;
	logic tck_s, tms_s, tdi_s, fcs_s, trst_n_s;

	bst_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d({tap_clock, tap_mode_select, tap_serial_in, framer_compat_select, tap_reset_n}),
		.q(pins_s)
	);
	assign {tck_s, tms_s, tdi_s, fcs_s, trst_n_s} = pins_s;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		bst_state_e st;
		logic [IR_LEN-1:0] ir_sh;
		logic [IR_LEN-1:0] ir;
		logic [ID_LEN-1:0] id_sh;
		logic byp;
		logic [BSR_LEN-1:0] bsr_sh;
		logic [BSR_LEN-1:0] bsr_upd;
		logic tck_prev;
		logic tdo;
		logic tdo_oe_n;
		logic legacy;
	} bst_tap_s;

	bst_tap_s s_r;
	bst_tap_s s_nxt;
	logic tap_rst;
	logic rise;
	logic fall;
	logic shifting;

	// the pin resets the controller directly, not through the synchroniser
	assign tap_rst = rst | ~tap_reset_n;
	assign rise = tck_s & ~s_r.tck_prev & trst_n_s; // no step until the reset release has settled
	assign fall = ~tck_s & s_r.tck_prev;
	assign shifting = (s_r.st == ST_SH_IR) || (s_r.st == ST_SH_DR);

	// next controller state from the sampled mode select
	function automatic bst_state_e step(input bst_state_e cur, input logic tms);
		unique case (cur)
			ST_TLR: step = tms ? ST_TLR : ST_RTI;
			ST_RTI: step = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: step = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: step = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: step = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: step = tms ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR: step = tms ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: step = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: step = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: step = tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: step = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: step = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: step = tms ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR: step = tms ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: step = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: step = tms ? ST_SEL_DR : ST_RTI;
		endcase
	endfunction : step

	// data register bit that leaves on the serial output
	function automatic logic dr_bit(input bst_tap_s s);
		unique case (s.ir)
			IR_IDCODE: dr_bit = s.id_sh[0];
			IR_EXTEST, IR_SAMPLE: dr_bit = s.bsr_sh[0];
			default: dr_bit = s.byp;
		endcase
	endfunction : dr_bit

	// ----------------------------------------------------------------
	// controller and registers
	// ----------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tck_prev = tck_s;
		s_nxt.legacy = fcs_s;
		if (fcs_s)
		begin
			// legacy mode keeps the port in reset
			s_nxt.st = ST_TLR;
			s_nxt.ir = IR_IDCODE;
			s_nxt.tdo_oe_n = 1'b1;
		end
		else if (rise)
		begin
			s_nxt.st = step(s_r.st, tms_s);
			unique case (s_r.st)
				ST_CAP_IR: s_nxt.ir_sh = IR_CAPTURE;
				ST_SH_IR: s_nxt.ir_sh = {tdi_s, s_r.ir_sh[IR_LEN-1:1]};
				ST_UPD_IR: s_nxt.ir = s_r.ir_sh;
				ST_CAP_DR:
				begin
					s_nxt.byp = 1'b0;
					s_nxt.id_sh = IDCODE_VAL;
					s_nxt.bsr_sh = bsr_capture;
				end
				ST_SH_DR:
				begin
					// only the register chosen by the instruction moves
					unique case (s_r.ir)
						IR_IDCODE: s_nxt.id_sh = {tdi_s, s_r.id_sh[ID_LEN-1:1]};
						IR_EXTEST, IR_SAMPLE: s_nxt.bsr_sh = {tdi_s, s_r.bsr_sh[BSR_LEN-1:1]};
						default: s_nxt.byp = tdi_s;
					endcase
				end
				ST_UPD_DR:
				begin
					if (s_r.ir == IR_EXTEST || s_r.ir == IR_SAMPLE)
						s_nxt.bsr_upd = s_r.bsr_sh;
				end
				default:
				begin
				end
			endcase
			// test logic reset always restores the id instruction
			if (s_nxt.st == ST_TLR)
				s_nxt.ir = IR_IDCODE;
		end
		else if (fall)
		begin
			// output moves only on the falling edge
			s_nxt.tdo = (s_r.st == ST_SH_IR) ? s_r.ir_sh[0] : dr_bit(s_r);
			s_nxt.tdo_oe_n = ~shifting;
		end
	end

	// state register with the tap reset folded in
	always_ff @(posedge clk or posedge tap_rst)
	begin
		if (tap_rst)
		begin
			s_r <= '0;
			s_r.st <= ST_TLR;
			s_r.ir <= IR_IDCODE;
			s_r.tdo_oe_n <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// outputs straight from flops, except extest_active, decoded from the instruction register
	assign tap_serial_out = s_r.tdo;
	assign tap_serial_out_oe_n = s_r.tdo_oe_n;
	assign bsr_update = s_r.bsr_upd;
	assign extest_active = (s_r.ir == IR_EXTEST);
	assign legacy_mode = s_r.legacy;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence seq_step;
		rise && !fcs_s;
	endsequence

	sequence seq_cap_bypass;
		seq_step ##0 (s_r.st == ST_CAP_DR) && (s_r.ir == IR_BYPASS);
	endsequence

	chk_reset_holds_tlr: assert property (!tap_reset_n |-> s_r.st == ST_TLR)
		else $error("controller left reset while reset pin low");
	chk_tlr_id_instr: assert property (s_r.st == ST_TLR |-> s_r.ir == IR_IDCODE)
		else $error("id instruction missing in reset state");
	chk_compat_forces_reset: assert property (fcs_s |=> s_r.st == ST_TLR && s_r.tdo_oe_n)
		else $error("compat select did not hold reset");
	chk_mode_follows_pin: assert property (disable iff (tap_rst) ##1 legacy_mode == $past(fcs_s))
		else $error("legacy mode not following compat select");
	chk_tms_walk_dr: assert property (seq_step ##0 s_r.st == ST_RTI && tms_s |=> s_r.st == ST_SEL_DR)
		else $error("run idle did not move to select dr");
	chk_tms_walk_tlr: assert property (seq_step ##0 s_r.st == ST_TLR && !tms_s |=> s_r.st == ST_RTI)
		else $error("reset state did not move to run idle");
	chk_tdi_ir_capture: assert property (seq_step ##0 s_r.st == ST_SH_IR |=>
		s_r.ir_sh[IR_LEN-1] == $past(tdi_s))
		else $error("serial input not captured into instruction");
	chk_tdo_on_fall: assert property (disable iff (tap_rst) !fall |=> $stable(tap_serial_out))
		else $error("serial output moved outside a falling edge");
	chk_tdo_hiz: assert property (!tap_serial_out_oe_n |->
		s_r.st inside {ST_SH_IR, ST_SH_DR, ST_EX1_IR, ST_EX1_DR})
		else $error("serial output driven outside shift");
	chk_bypass_capture: assert property (seq_cap_bypass |=>
		!s_r.byp && s_r.st inside {ST_SH_DR, ST_EX1_DR})
		else $error("bypass cell not cleared on capture");
	chk_upd_ir_load: assert property (seq_step ##0 s_r.st == ST_UPD_IR |=>
		s_r.ir == $past(s_r.ir_sh))
		else $error("instruction not loaded on update");
endmodule : bst_tap

/* File: bst_tester.sv */
// scan tester model: drives the tap pins and reads the serial output
// assumes clk is the bench clock; tap_clock runs only inside cyc
`timescale 1ns/1ps

module bst_tester (
	input wire logic clk,
	input wire logic tap_serial_out,
	input wire logic tap_serial_out_oe_n,
	output logic tap_clock,
	output logic tap_reset_n,
	output logic tap_mode_select,
	output logic tap_serial_in
);
	// test reset held low while the port is unused, clock stands low
	initial
	begin
		tap_clock = 1'b0;
		tap_reset_n = 1'b0;
		tap_mode_select = 1'b1;
		tap_serial_in = 1'b1;
	end

	// test reset low then high before first use
	task automatic pulse_rst();
		tap_reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		tap_reset_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : pulse_rst

	// one 80 ns tap_clock period; q and e are what the port showed after the last fall
	task automatic cyc(input logic m, input logic d, output logic q, output logic e);
		tap_mode_select <= m;
		tap_serial_in <= d;
		repeat (8) @(posedge clk);
		// a released output has no pull, so the model reads it inverted
		q = tap_serial_out_oe_n ? ~tap_serial_out : tap_serial_out;
		e = tap_serial_out_oe_n;
		tap_clock <= 1'b1;
		repeat (8) @(posedge clk);
		tap_clock <= 1'b0;
	endtask : cyc
endmodule : bst_tester

/* File: tb_top.sv */
// self-checking bench for the boundary-scan port
// assumes bst_pkg, bst_tap and bst_tester are compiled first
`timescale 1ns/1ps
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin n_fail++; $display("FAIL %s exp %0h got %0h", n, x, g); end end

module tb_top
	import bst_pkg::*;
;
	localparam int BL = 8;
	localparam logic [31:0] ID = 32'hA5C3_0F01; // arbitrary value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic framer_compat_select = 1'b0;
	logic [BL-1:0] bsr_capture = '0;
	logic tck, trst_n, tms, tdi, tdo, oe_n, ext, leg, tdo_q;
	logic [BL-1:0] bsr_update;
	logic [63:0] dout;
	logic [31:0] seed = 32'h4BC9;
	logic [31:0] r;
	logic [3:0] c;
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;

	bst_tap #(.BSR_LEN(BL), .IDCODE_VAL(ID)) bst_tap_i (
		.clk(clk), .rst(rst), .tap_clock(tck), .tap_reset_n(trst_n),
		.tap_mode_select(tms), .tap_serial_in(tdi), .framer_compat_select(framer_compat_select),
		.bsr_capture(bsr_capture), .tap_serial_out(tdo), .tap_serial_out_oe_n(oe_n),
		.bsr_update(bsr_update), .extest_active(ext), .legacy_mode(leg)
	);
	bst_tester bst_tester_i (
		.clk(clk), .tap_serial_out(tdo), .tap_serial_out_oe_n(oe_n), .tap_clock(tck),
		.tap_reset_n(trst_n), .tap_mode_select(tms), .tap_serial_in(tdi)
	);

	always #2.5 clk = ~clk;

	// ----
	// helpers
	// ----
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// walk tms bits lsb first
	task automatic mv(input logic [7:0] b, input int n);
		logic q, e;
		for (int i = 0; i < n; i++)
			bst_tester_i.cyc(b[i], 1'b1, q, e);
	endtask : mv

	// shift n bits from a shift state, then update and idle
	task automatic shf(input int n, input logic [63:0] din, input logic oe);
		logic q, e;
		for (int i = 0; i < n; i++)
		begin
			bst_tester_i.cyc(i == n - 1, din[i], q, e);
			dout[i] = q;
			`CHK("oe_n shift", oe, e)
		end
		bst_tester_i.cyc(1'b1, 1'b1, q, e);
		`CHK("oe_n exit", 1'b1, e)
		mv(8'h00, 1);
	endtask : shf

	task automatic ir(input logic [3:0] code);
		mv(8'h03, 4);
		shf(4, {60'h0, code}, 1'b0);
		`CHK("ir capture", IR_CAPTURE, dout[3:0])
	endtask : ir

	task automatic dr(input int n, input logic [63:0] din);
		mv(8'h01, 3);
		shf(n, din, 1'b0);
	endtask : dr

	task automatic stop_test(input logic to);
		if (to)
			n_fail++;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// serial out may move only while tap_clock is low; run limit
	always @(posedge clk)
	begin
		tdo_q <= tdo;
		cycles++;
		if (tck && tdo_q !== tdo)
			`CHK("tdo high phase", tdo_q, tdo)
		if (cycles == 20000)
			stop_test(1'b1);
	end

	// ----
	// scenarios
	// ----
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		bst_tester_i.pulse_rst();
		mv(8'h00, 1);
		dr(32, {rnd(), rnd()});
		`CHK("idcode", ID, dout[31:0])
		$display("test idcode done");
		for (int i = 0; i < 3; i++)
		begin
			r = rnd();
			c = (i == 0) ? IR_BYPASS : (r[3:0] | 4'h4);
			ir(c);
			r = rnd();
			dr(9, {32'h0, r});
			`CHK("bypass", {r[7:0], 1'b0}, dout[8:0])
		end
		$display("test bypass done");
		r = rnd();
		bsr_capture <= r[BL-1:0];
		ir(IR_SAMPLE);
		r = rnd();
		dr(BL, {32'h0, r});
		`CHK("bsr capture", bsr_capture, dout[BL-1:0])
		`CHK("bsr update", r[BL-1:0], bsr_update)
		`CHK("extest off", 1'b0, ext)
		ir(IR_EXTEST);
		`CHK("extest on", 1'b1, ext)
		$display("test boundary done");
		// stop inside a data shift so the reset has a driven output to release
		mv(8'h01, 3);
		repeat (6) @(posedge clk);
		`CHK("oe before reset", 1'b0, oe_n)
		bst_tester_i.tap_reset_n <= 1'b0;
		#2;
		`CHK("async ir", 1'b0, ext)
		`CHK("async oe", 1'b1, oe_n)
		`CHK("async bsr", {BL{1'b0}}, bsr_update)
		@(posedge clk);
		bst_tester_i.tap_reset_n <= 1'b1;
		mv(8'h00, 1);
		dr(32, {rnd(), rnd()});
		`CHK("idcode again", ID, dout[31:0])
		$display("test reset done");
		ir(IR_EXTEST);
		framer_compat_select <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("legacy on", 1'b1, leg)
		`CHK("compat reset", 1'b0, ext)
		mv(8'h03, 4);
		shf(4, 64'h0, 1'b1);
		`CHK("compat ignore", 1'b0, ext)
		framer_compat_select <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("legacy off", 1'b0, leg)
		mv(8'h00, 1);
		dr(32, {rnd(), rnd()});
		`CHK("idcode native", ID, dout[31:0])
		$display("test compat done");
		stop_test(1'b0);
	end
endmodule : tb_top
